// ---- hw/rsr_exec_regs.svh ----
/*
  Constants for the rotate, subtract and return execution block: opcode
  patterns, instruction field positions, flag positions, reset values and
  the quarter-cycle count.
  Assumes inclusion by bare name from the package and the property checker.
*/
`ifndef RSR_EXEC_REGS_SVH
`define RSR_EXEC_REGS_SVH

`define RSR_Q_PER_CYCLE    4
`define RSR_Q_DECODE       2'h0
`define RSR_Q_READ         2'h1
`define RSR_Q_PROCESS      2'h2
`define RSR_Q_WRITE        2'h3

`define RSR_OPC_RETURN     15'h0009
`define RSR_OPC_SLEEP      16'h0003
`define RSR_OPC_RLC        6'h0D
`define RSR_OPC_RLN        6'h11
`define RSR_OPC_RRC        6'h0C
`define RSR_OPC_RRN        6'h10
`define RSR_OPC_FILL_ONES_OP       7'h34
`define RSR_OPC_SUBB       6'h15
`define RSR_OPC_SUBL       8'h08
`define RSR_OPC_SUBW       6'h17

`define RSR_BIT_S          0
`define RSR_BIT_D          9
`define RSR_BIT_A          8

`define RSR_FLG_C          0
`define RSR_FLG_DC         1
`define RSR_FLG_Z          2
`define RSR_FLG_OV         3
`define RSR_FLG_N          4

`define RSR_ACCESS_HI_BANK 4'hF
`define RSR_ACCESS_LO_BANK 4'h0
`define RSR_ONES           8'hFF

`define RSR_RST_ACCUM      8'h00
`define RSR_RST_FLAGS      5'h00
`define RSR_RST_BANK       4'h0
`define RSR_RST_PC         21'h00_0000
`define RSR_RST_PD         1'b1
`define RSR_RST_TO         1'b1

`endif

// ---- hw/rsr_pkg.sv ----
/*
  Types shared by the execution block: operation kinds.
  Assumes the constants header is on the include path.
*/
package rsr_pkg;
  `include "rsr_exec_regs.svh"

  typedef enum logic [3:0] {
    RSR_OP_NONE  = 4'b0000,
    RSR_OP_RET   = 4'b0001,
    RSR_OP_SLEEP = 4'b0010,
    RSR_OP_RLC   = 4'b0011,
    RSR_OP_RLN   = 4'b0100,
    RSR_OP_RRC   = 4'b0101,
    RSR_OP_RRN   = 4'b0110,
    RSR_OP_FILL_ONES_OP  = 4'b0111,
    RSR_OP_SUBB  = 4'b1000,
    RSR_OP_SUBL  = 4'b1001,
    RSR_OP_SUBW  = 4'b1010
  } rsr_op_t;
endpackage : rsr_pkg

// ---- hw/rsr_regfile.sv ----
/*
  Two-port data memory for the register file.
  Port A serves the execution core, port B the software port. Read data of
  each port come out of a register one cycle after the read strobe.
  Assumes both ports run on the same clock; on a write collision port A wins.
*/
`timescale 1ns/1ns
module rsr_regfile #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input  wire logic          clk_i,
  input  wire logic [AW-1:0] a_addr_i,
  input  wire logic          a_rd_i,
  input  wire logic          a_wr_i,
  input  wire logic [DW-1:0] a_wdata_i,
  output logic      [DW-1:0] a_rdata_o,
  input  wire logic [AW-1:0] b_addr_i,
  input  wire logic          b_rd_i,
  input  wire logic          b_wr_i,
  input  wire logic [DW-1:0] b_wdata_i,
  output logic      [DW-1:0] b_rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (b_wr_i) begin
      mem[b_addr_i] <= b_wdata_i;
    end
    if (a_wr_i) begin
      mem[a_addr_i] <= a_wdata_i;
    end
    if (a_rd_i) begin
      a_rdata_o <= mem[a_addr_i];
    end
    if (b_rd_i) begin
      b_rdata_o <= mem[b_addr_i];
    end
  end
endmodule : rsr_regfile

// ---- hw/rsr_exec.sv ----
/*
  Execution logic for subroutine return, rotates, fill-with-ones, sleep
  entry and three subtract forms of an 8-bit core, with its data memory.
  Assumes the decoder offers an instruction word with a valid level on the
  same clock and holds it until taken, and that the return stack pops when
  asked and shows its top on the stack input.
*/
`timescale 1ns/1ns
// Behaviour
// RQ1: Return pops the stack and loads the popped top into the program counter.
// RQ2: Return with s set restores accumulator, flags and bank from shadows.
// RQ3: Return takes two cycles, second idle, leaving both pc latches alone.
// RQ4: Rotate left through carry, bit 7 to carry; updates C, N, Z.
// RQ5: Rotate left plain, bit 7 wraps to bit 0; updates N and Z only.
// RQ6: Rotate right through carry, bit 0 to carry; updates C, N, Z.
// RQ7: Rotate right plain, bit 0 wraps to bit 7; updates N and Z only.
// RQ8: Destination bit zero writes the accumulator, one writes the register.
// RQ9: Access bit zero uses the access bank, one uses the bank select.
// RQ10: Fill-ones writes all ones to the register, flags untouched.
// RQ11: Sleep clears powerdown, sets timeout, then halts the clock phases.
// RQ12: Sleep clears the watchdog counter and its postscaler.
// RQ13: Accumulator minus register minus inverted carry; updates five flags.
// RQ14: Literal minus accumulator into the accumulator; updates five flags.
// RQ15: Register minus accumulator, routed by destination; updates five flags.
// RQ16: Subtraction carry is an inverted borrow.
// RQ17: Decode, read, process and write fall in quarter cycles one to four.
module rsr_exec
  import rsr_pkg::*;
#(
  parameter int AW       = 12,
  parameter int WDT_W    = 8,
  parameter int WDT_PS_W = 7
) (
  input  wire logic          REF_CLK_I,
  input  wire logic          SRST_I,
  input  wire logic [15:0]   INSTR_I,
  input  wire logic          INSTR_VALID_I,
  output logic               INSTR_TAKEN_O,
  input  wire logic [20:0]   STACK_TOP_I,
  output logic               STACK_POP_O,
  output logic               PC_LOAD_O,
  output logic [20:0]        PC_O,
  input  wire logic [7:0]    SHADOW_ACCUM_I,
  input  wire logic [4:0]    SHADOW_FLAGS_I,
  input  wire logic [3:0]    SHADOW_BANK_SEL_I,
  output logic [7:0]         ACCUM_O,
  output logic [4:0]         FLAGS_O,
  output logic [3:0]         BANK_SEL_O,
  input  wire logic          WAKE_I,
  output logic               SLEEP_O,
  output logic               POWERDOWN_FLAG_O,
  output logic               TIMEOUT_FLAG_O,
  output logic               WDT_EXPIRE_O,
  output logic [1:0]         PHASE_O,
  output logic               BUSY_O,
  input  wire logic [AW-1:0] SW_ADDR_I,
  input  wire logic [7:0]    SW_WDATA_I,
  input  wire logic          SW_WR_I,
  input  wire logic          SW_RD_I,
  output logic [7:0]         SW_RDATA_O
);
  import rsr_pkg::*;

  function automatic rsr_op_t decode_op(input logic [15:0] w);
    rsr_op_t op;
    op = RSR_OP_NONE;
    if (w[15:1] == `RSR_OPC_RETURN) begin
      op = RSR_OP_RET;
    end else if (w == `RSR_OPC_SLEEP) begin
      op = RSR_OP_SLEEP;
    end else if (w[15:10] == `RSR_OPC_RLC) begin
      op = RSR_OP_RLC;
    end else if (w[15:10] == `RSR_OPC_RLN) begin
      op = RSR_OP_RLN;
    end else if (w[15:10] == `RSR_OPC_RRC) begin
      op = RSR_OP_RRC;
    end else if (w[15:10] == `RSR_OPC_RRN) begin
      op = RSR_OP_RRN;
    end else if (w[15:9] == `RSR_OPC_FILL_ONES_OP) begin
      op = RSR_OP_FILL_ONES_OP;
    end else if (w[15:10] == `RSR_OPC_SUBB) begin
      op = RSR_OP_SUBB;
    end else if (w[15:8] == `RSR_OPC_SUBL) begin
      op = RSR_OP_SUBL;
    end else if (w[15:10] == `RSR_OPC_SUBW) begin
      op = RSR_OP_SUBW;
    end
    return op;
  endfunction : decode_op

  logic [1:0]          phase_reg;
  logic                active_reg;
  logic                second_reg;
  rsr_op_t             op_reg;
  logic [15:0]         instr_reg;
  logic [7:0]          result_reg;
  logic [4:0]          newflags_reg;
  logic [7:0]          accum_reg;
  logic [4:0]          flags_reg;
  logic [3:0]          bank_select_reg;
  logic [20:0]         pc_reg;
  logic                taken_reg;
  logic                busy_reg;
  logic                pop_reg;
  logic                pcload_reg;
  logic                sleep_reg;
  logic                powerdown_flag_reg;
  logic                timeout_flag_reg;
  logic                wake_meta_reg;
  logic                wake_sync_reg;
  logic [WDT_W-1:0]    watchdog_counter_reg;
  logic [WDT_PS_W-1:0] wdt_post_reg;
  logic                wdt_expire_reg;

  wire        q_decode  = (phase_reg == `RSR_Q_DECODE);
  wire        q_read    = (phase_reg == `RSR_Q_READ);
  wire        q_process = (phase_reg == `RSR_Q_PROCESS);
  wire        q_write   = (phase_reg == `RSR_Q_WRITE);
  wire        take      = q_decode && !sleep_reg && !second_reg && INSTR_VALID_I;
  wire        bit_d     = instr_reg[`RSR_BIT_D];
  wire        bit_a     = instr_reg[`RSR_BIT_A];
  wire        bit_s     = instr_reg[`RSR_BIT_S];
  wire [7:0]  f_addr    = instr_reg[7:0];
  wire        carry_in  = flags_reg[`RSR_FLG_C];

  // Access bank maps the low half to bank zero and the high half to the top bank.
  wire [3:0]    access_bank = f_addr[7] ? `RSR_ACCESS_HI_BANK : `RSR_ACCESS_LO_BANK;
  wire [3:0]    eff_bank    = bit_a ? bank_select_reg : access_bank; // RQ9
  wire [AW-1:0] mem_addr    = AW'({eff_bank, f_addr});

  wire is_ret   = (op_reg == RSR_OP_RET);
  wire is_sleep = (op_reg == RSR_OP_SLEEP);
  wire is_fill_ones_op  = (op_reg == RSR_OP_FILL_ONES_OP);
  wire is_subl  = (op_reg == RSR_OP_SUBL);
  wire is_sub   = (op_reg == RSR_OP_SUBB) || is_subl || (op_reg == RSR_OP_SUBW);
  wire is_rot   = (op_reg == RSR_OP_RLC) || (op_reg == RSR_OP_RLN) ||
                  (op_reg == RSR_OP_RRC) || (op_reg == RSR_OP_RRN);
  wire uses_mem = is_rot || is_fill_ones_op || (op_reg == RSR_OP_SUBB) ||
                  (op_reg == RSR_OP_SUBW);

  wire mem_rd = active_reg && q_read && uses_mem && !is_fill_ones_op; // RQ17
  wire [7:0] mem_rdata;

  // Subtraction as minuend plus inverted subtrahend plus carry-in.
  logic [7:0] minuend;
  logic [7:0] subtrahend;
  logic       sub_cin;
  always_comb begin
    minuend    = mem_rdata;
    subtrahend = accum_reg;
    sub_cin    = 1'b1;
    if (op_reg == RSR_OP_SUBB) begin
      minuend    = accum_reg; // RQ13
      subtrahend = mem_rdata;
      sub_cin    = carry_in;
    end else if (is_subl) begin
      minuend    = instr_reg[7:0]; // RQ14
      subtrahend = accum_reg;
    end
  end

  wire [4:0] lo_sum  = 5'({1'b0, minuend[3:0]}) + 5'({1'b0, ~subtrahend[3:0]}) + 5'(sub_cin);
  wire [8:0] sub_sum = 9'({1'b0, minuend}) + 9'({1'b0, ~subtrahend}) + 9'(sub_cin);
  wire [7:0] sub_res = sub_sum[7:0];
  wire       sub_c   = sub_sum[8]; // RQ16
  wire       sub_dc  = lo_sum[4];
  wire       sub_ov  = (minuend[7] != subtrahend[7]) && (sub_res[7] != minuend[7]);

  logic [7:0] calc_res;
  logic [4:0] calc_flags;
  always_comb begin
    calc_res   = mem_rdata;
    calc_flags = flags_reg;
    case (op_reg)
      RSR_OP_RLC: begin
        calc_res               = {mem_rdata[6:0], carry_in}; // RQ4
        calc_flags[`RSR_FLG_C] = mem_rdata[7];
      end
      RSR_OP_RLN: begin
        calc_res = {mem_rdata[6:0], mem_rdata[7]}; // RQ5
      end
      RSR_OP_RRC: begin
        calc_res               = {carry_in, mem_rdata[7:1]}; // RQ6
        calc_flags[`RSR_FLG_C] = mem_rdata[0];
      end
      RSR_OP_RRN: begin
        calc_res = {mem_rdata[0], mem_rdata[7:1]}; // RQ7
      end
      RSR_OP_FILL_ONES_OP: begin
        calc_res = `RSR_ONES; // RQ10
      end
      RSR_OP_SUBB, RSR_OP_SUBL, RSR_OP_SUBW: begin
        calc_res                = sub_res; // RQ15
        calc_flags[`RSR_FLG_C]  = sub_c;
        calc_flags[`RSR_FLG_DC] = sub_dc;
        calc_flags[`RSR_FLG_OV] = sub_ov;
      end
      default: begin
        calc_res = mem_rdata;
      end
    endcase
    if (is_rot || is_sub) begin
      calc_flags[`RSR_FLG_N] = calc_res[7];
      calc_flags[`RSR_FLG_Z] = (calc_res == 8'h00);
    end
  end

  wire wr_phase   = active_reg && q_write;
  wire to_accum   = is_subl || ((is_rot || is_sub) && !bit_d); // RQ8
  wire mem_wr     = wr_phase && (is_fill_ones_op || ((is_rot || is_sub) && !is_subl && bit_d));
  wire ret_fire   = wr_phase && is_ret;
  wire sleep_fire = wr_phase && is_sleep;

  rsr_regfile #(
    .AW (AW),
    .DW (8)
  ) u_regfile (
    .clk_i     (REF_CLK_I),
    .a_addr_i  (mem_addr),
    .a_rd_i    (mem_rd),
    .a_wr_i    (mem_wr),
    .a_wdata_i (result_reg),
    .a_rdata_o (mem_rdata),
    .b_addr_i  (SW_ADDR_I),
    .b_rd_i    (SW_RD_I),
    .b_wr_i    (SW_WR_I),
    .b_wdata_i (SW_WDATA_I),
    .b_rdata_o (SW_RDATA_O)
  );

  // Phases stop while asleep, standing in for the halted oscillator.
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      phase_reg <= `RSR_Q_DECODE;
    end else if (!sleep_reg) begin
      phase_reg <= phase_reg + 2'h1; // RQ17
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      active_reg <= 1'b0;
      op_reg     <= RSR_OP_NONE;
      instr_reg  <= 16'h0000;
      taken_reg  <= 1'b0;
      busy_reg   <= 1'b0;
    end else begin
      taken_reg <= take;
      busy_reg  <= take || ret_fire || ((active_reg || second_reg) && !q_write);
      if (take) begin
        active_reg <= 1'b1; // RQ17
        op_reg     <= decode_op(INSTR_I);
        instr_reg  <= INSTR_I;
      end else if (q_write) begin
        active_reg <= 1'b0;
      end
    end
  end

  // The second return cycle holds off the next instruction and does nothing.
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      second_reg <= 1'b0;
    end else if (ret_fire) begin
      second_reg <= 1'b1; // RQ3
    end else if (q_write) begin
      second_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      result_reg   <= 8'h00;
      newflags_reg <= `RSR_RST_FLAGS;
    end else if (active_reg && q_process) begin
      result_reg   <= calc_res;
      newflags_reg <= calc_flags;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      accum_reg       <= `RSR_RST_ACCUM;
      flags_reg       <= `RSR_RST_FLAGS;
      bank_select_reg <= `RSR_RST_BANK;
    end else if (ret_fire) begin
      if (bit_s) begin
        accum_reg       <= SHADOW_ACCUM_I; // RQ2
        flags_reg       <= SHADOW_FLAGS_I;
        bank_select_reg <= SHADOW_BANK_SEL_I;
      end
    end else if (wr_phase) begin
      if (to_accum) begin
        accum_reg <= result_reg; // RQ8
      end
      if (is_rot || is_sub) begin
        flags_reg <= newflags_reg;
      end
    end
  end

  // The pc and the pop and load pulses are driven from here, registered off the return's write quarter.
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      pc_reg     <= `RSR_RST_PC;
      pop_reg    <= 1'b0;
      pcload_reg <= 1'b0;
    end else begin
      pop_reg    <= ret_fire; // RQ1
      pcload_reg <= ret_fire;
      if (ret_fire) begin
        pc_reg <= STACK_TOP_I; // RQ1
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
    end else begin
      wake_meta_reg <= WAKE_I;
      wake_sync_reg <= wake_meta_reg;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      sleep_reg          <= 1'b0;
      powerdown_flag_reg <= `RSR_RST_PD;
      timeout_flag_reg   <= `RSR_RST_TO;
    end else if (sleep_fire) begin
      sleep_reg          <= 1'b1; // RQ11
      powerdown_flag_reg <= 1'b0;
      timeout_flag_reg   <= 1'b1;
    end else if (sleep_reg && wake_sync_reg) begin
      sleep_reg <= 1'b0;
    end
  end

  // Watchdog keeps running in sleep; the postscaler wrap marks an expiry.
  wire wdt_wrap = &watchdog_counter_reg;
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I || sleep_fire) begin
      watchdog_counter_reg <= '0; // RQ12
      wdt_post_reg         <= '0;
      wdt_expire_reg       <= 1'b0;
    end else begin
      watchdog_counter_reg <= watchdog_counter_reg + WDT_W'(1);
      if (wdt_wrap) begin
        wdt_post_reg <= wdt_post_reg + WDT_PS_W'(1);
      end
      wdt_expire_reg <= wdt_wrap && (&wdt_post_reg);
    end
  end

  assign INSTR_TAKEN_O    = taken_reg;
  assign STACK_POP_O      = pop_reg;
  assign PC_LOAD_O        = pcload_reg;
  assign PC_O             = pc_reg;
  assign ACCUM_O          = accum_reg;
  assign FLAGS_O          = flags_reg;
  assign BANK_SEL_O       = bank_select_reg;
  assign SLEEP_O          = sleep_reg;
  assign POWERDOWN_FLAG_O = powerdown_flag_reg;
  assign TIMEOUT_FLAG_O   = timeout_flag_reg;
  assign WDT_EXPIRE_O     = wdt_expire_reg;
  assign PHASE_O          = phase_reg;
  assign BUSY_O           = busy_reg;
endmodule : rsr_exec

// ---- test/rsr_exec_properties.sv ----
/* Port timing checker for the rotate, subtract and return execution block.
   Assumes one clock domain and binding onto rsr_exec below. */
`timescale 1ns/1ns
`include "rsr_exec_regs.svh"
module rsr_exec_properties #(
  parameter int AW       = 12,
  parameter int WDT_W    = 8,
  parameter int WDT_PS_W = 7
) (
  input wire logic        REF_CLK_I,
  input wire logic        SRST_I,
  input wire logic [15:0] INSTR_I,
  input wire logic        INSTR_TAKEN_O,
  input wire logic [20:0] STACK_TOP_I,
  input wire logic        STACK_POP_O,
  input wire logic        PC_LOAD_O,
  input wire logic [20:0] PC_O,
  input wire logic [7:0]  ACCUM_O,
  input wire logic [4:0]  FLAGS_O,
  input wire logic        SLEEP_O,
  input wire logic        POWERDOWN_FLAG_O,
  input wire logic        TIMEOUT_FLAG_O,
  input wire logic        WDT_EXPIRE_O,
  input wire logic [1:0]  PHASE_O,
  input wire logic        BUSY_O
);
  // Word that was on the instruction port at the taking edge.
  logic [15:0] word_q;
  always_ff @(posedge REF_CLK_I) word_q <= INSTR_I;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);

  AST_POP_LOADS_TOP: assert property (PC_LOAD_O |-> STACK_POP_O && PC_O == $past(STACK_TOP_I))
    else $error("return did not load the popped stack top");
  AST_RET_SECOND_CYCLE: assert property (PC_LOAD_O |-> BUSY_O [*4] ##1 !BUSY_O)
    else $error("return second cycle has wrong length");
  AST_RET_NO_TAKE: assert property (PC_LOAD_O |-> !INSTR_TAKEN_O [*5])
    else $error("instruction taken during return second cycle");
  AST_TAKE_IN_Q1: assert property (INSTR_TAKEN_O |-> PHASE_O == 2'h1 && $past(PHASE_O) == 2'h0)
    else $error("instruction taken outside the first quarter");
  AST_PHASE_STEP: assert property (PHASE_O != 2'h0 |=> PHASE_O == $past(PHASE_O) + 2'h1)
    else $error("quarter cycle did not advance");
  AST_WRITE_IN_Q4: assert property (!$stable({ACCUM_O, FLAGS_O}) |-> PHASE_O == 2'h0)
    else $error("result written outside the fourth quarter");
  AST_FILL_KEEPS_FLAGS: assert property (INSTR_TAKEN_O &&
    word_q[15:9] == `RSR_OPC_FILL_ONES_OP |-> $stable(FLAGS_O) [*4])
    else $error("fill with ones changed the flags");
  AST_PLAIN_KEEPS_C: assert property (INSTR_TAKEN_O &&
    (word_q[15:10] == `RSR_OPC_RLN || word_q[15:10] == `RSR_OPC_RRN) |->
    $stable(FLAGS_O[0]) [*4])
    else $error("plain rotate changed the carry");
  AST_SLEEP_FLAGS: assert property ($rose(SLEEP_O) |-> !POWERDOWN_FLAG_O && TIMEOUT_FLAG_O)
    else $error("sleep entry left wrong status flags");
  AST_SLEEP_FROZEN: assert property (SLEEP_O |=> PHASE_O == 2'h0 && !INSTR_TAKEN_O)
    else $error("phases ran while asleep");
  AST_SLEEP_WDT_CLEAR: assert property ($rose(SLEEP_O) |-> !WDT_EXPIRE_O [*8])
    else $error("watchdog expired right after sleep entry");

  COV_RETURN: cover property (PC_LOAD_O);
  COV_SLEEP: cover property ($rose(SLEEP_O));
  COV_FILL: cover property (INSTR_TAKEN_O && word_q[15:9] == `RSR_OPC_FILL_ONES_OP);
endmodule : rsr_exec_properties

bind rsr_exec rsr_exec_properties #(.AW(AW), .WDT_W(WDT_W), .WDT_PS_W(WDT_PS_W)) u_props (
  .REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .INSTR_I(INSTR_I), .INSTR_TAKEN_O(INSTR_TAKEN_O),
  .STACK_TOP_I(STACK_TOP_I), .STACK_POP_O(STACK_POP_O), .PC_LOAD_O(PC_LOAD_O), .PC_O(PC_O),
  .ACCUM_O(ACCUM_O), .FLAGS_O(FLAGS_O), .SLEEP_O(SLEEP_O), .POWERDOWN_FLAG_O(POWERDOWN_FLAG_O),
  .TIMEOUT_FLAG_O(TIMEOUT_FLAG_O), .WDT_EXPIRE_O(WDT_EXPIRE_O), .PHASE_O(PHASE_O),
  .BUSY_O(BUSY_O));

// ---- test/rsr_stack_model.sv ----
/* Return stack model standing on the far side of the block.
   Assumes pops are one-cycle pulses on the block clock. */
`timescale 1ns/1ns
module rsr_stack_model (
  input  wire logic        clk_i,
  input  wire logic        pop_i,
  output logic      [20:0] top_o,
  output int               depth_o
);
  logic [20:0] mem [0:7];
  int          depth = 0;
  assign depth_o = depth;
  // An empty stack shows a toggling pattern so a stale top is never trusted.
  assign top_o = (depth > 0) ? mem[depth-1] : {21{clk_i}};
  task automatic push(input logic [20:0] v);
    mem[depth] = v;
    depth = depth + 1;
  endtask : push
  always @(posedge clk_i) begin
    if (pop_i && depth > 0) depth <= depth - 1;
  end
endmodule : rsr_stack_model

// ---- test/rsr_exec_bench.sv ----
/* Bench for rsr_exec: runs each instruction against a reference model
   and reads memory results back over the software port.
   Assumes the stack model and the checker are compiled before it. */
`timescale 1ns/1ns
module rsr_exec_bench;
  logic        clk = 1'b0, srst = 1'b1, valid = 1'b0, wake = 1'b0;
  logic        sw_wr = 1'b0, sw_rd = 1'b0, taken, pop, pc_load, sleep, pd, to, wdt_exp, busy;
  logic [15:0] instr = 16'h0000;
  logic [20:0] top, pc;
  logic [7:0]  sh_acc = 8'h02, sw_wdata = 8'h00, acc_m = 8'h00, acc, sw_rdata, got;
  logic [4:0]  sh_flg = 5'h01, flg_m = 5'h00, flg;
  logic [3:0]  sh_bank = 4'h2, bank_m = 4'h0, bank;
  logic [11:0] sw_addr = 12'h000;
  logic [1:0]  phase;
  logic [7:0]  mem_m [logic [11:0]];
  int          depth, n_mismatch = 0, n_tests = 0;
  logic [15:0] ops [11] = '{16'h3420, 16'h4690, 16'h3310, 16'h4110, 16'h6911, 16'h5620,
                            16'h5C90, 16'h0802, 16'h5F10, 16'h0880, 16'h5511};

  rsr_exec #(.AW(12), .WDT_W(3), .WDT_PS_W(2)) u_dut (
    .REF_CLK_I(clk), .SRST_I(srst), .INSTR_I(instr), .INSTR_VALID_I(valid),
    .INSTR_TAKEN_O(taken), .STACK_TOP_I(top), .STACK_POP_O(pop), .PC_LOAD_O(pc_load),
    .PC_O(pc), .SHADOW_ACCUM_I(sh_acc), .SHADOW_FLAGS_I(sh_flg),
    .SHADOW_BANK_SEL_I(sh_bank), .ACCUM_O(acc), .FLAGS_O(flg), .BANK_SEL_O(bank),
    .WAKE_I(wake), .SLEEP_O(sleep), .POWERDOWN_FLAG_O(pd), .TIMEOUT_FLAG_O(to),
    .WDT_EXPIRE_O(wdt_exp), .PHASE_O(phase), .BUSY_O(busy), .SW_ADDR_I(sw_addr),
    .SW_WDATA_I(sw_wdata), .SW_WR_I(sw_wr), .SW_RD_I(sw_rd), .SW_RDATA_O(sw_rdata));
  rsr_stack_model u_stack (.clk_i(clk), .pop_i(pop), .top_o(top), .depth_o(depth));

  always #5 clk = ~clk;

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_sig(ref logic s, input logic v);
    int i;
    for (i = 0; i < 40 && s !== v; i++) @(posedge clk);
    if (s !== v) begin
      n_mismatch++;
      $display("MISMATCH handshake expected %b seen %b", v, s);
      finish_test();
    end
  endtask : wait_sig

  task automatic sw_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    mem_m[a] = d;
  endtask : sw_write

  task automatic sw_read(input logic [11:0] a);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(posedge clk);
    got = sw_rdata;
  endtask : sw_read

  // Carry out of x + ~y + ci is the inverted borrow.
  function automatic logic [12:0] sub(input logic [7:0] x, y, input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, x} + {1'b0, ~y} + 9'(ci);
    h = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + 5'(ci);
    return {s[7], (x[7] != y[7]) && (s[7] != x[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction : sub

  // Predicts flags and destination of one word, then compares the ports.
  task automatic model(input logic [15:0] w);
    logic [11:0] ad;
    logic [7:0]  v, r;
    logic [12:0] t;
    ad = {w[8] ? bank_m : {4{w[7]}}, w[7:0]};
    v = mem_m.exists(ad) ? mem_m[ad] : 8'h00;
    t = {flg_m, acc_m};
    case (w[15:10])
      6'h0D: begin
        r = {v[6:0], flg_m[0]};
        t = {r[7], flg_m[3], r == 8'h00, flg_m[1], v[7], r};
      end
      6'h11: begin
        r = {v[6:0], v[7]};
        t = {r[7], flg_m[3], r == 8'h00, flg_m[1:0], r};
      end
      6'h0C: begin
        r = {flg_m[0], v[7:1]};
        t = {r[7], flg_m[3], r == 8'h00, flg_m[1], v[0], r};
      end
      6'h10: begin
        r = {v[0], v[7:1]};
        t = {r[7], flg_m[3], r == 8'h00, flg_m[1:0], r};
      end
      6'h15: t = sub(acc_m, v, flg_m[0]);
      6'h17: t = sub(v, acc_m, 1'b1);
      6'h02: t = sub(w[7:0], acc_m, 1'b1);
      6'h1A: t = {flg_m, 8'hFF};
      default: if (w[15:1] == 15'h0009 && w[0]) {bank_m, t} = {sh_bank, sh_flg, sh_acc};
    endcase
    flg_m = t[12:8];
    if (w[9] || w[15:10] == 6'h1A) mem_m[ad] = t[7:0];
    else acc_m = t[7:0];
    check("accumulator", acc_m, acc);
    check("flags", flg_m, flg);
    check("bank select", bank_m, bank);
    if (w[9] || w[15:10] == 6'h1A) begin
      sw_read(ad);
      check("memory", mem_m[ad], got);
    end
  endtask : model

  task automatic exec(input logic [15:0] w);
    @(posedge clk);
    instr <= w;
    valid <= 1'b1;
    wait_sig(taken, 1'b1);
    valid <= 1'b0;
    wait_sig(busy, 1'b0);
    model(w);
  endtask : exec

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    sw_write(12'h020, 8'hE6);
    sw_write(12'hF90, 8'hAB);
    sw_write(12'h210, 8'h81);
    u_stack.push(21'h0A_BCDE);
    u_stack.push(21'h1F_0123);
    exec(16'h0013);
    check("pc", 21'h1F_0123, pc);
    check("stack depth", 1, depth);
    sh_acc <= 8'h55;
    sh_flg <= 5'h1E;
    sh_bank <= 4'h7;
    exec(16'h0012);
    check("pc", 21'h0A_BCDE, pc);
    // Rotates, fill and subtracts over both bank modes and both destinations.
    foreach (ops[i]) exec(ops[i]);
    exec(16'h0003);
    check("sleep", 1, sleep);
    check("powerdown", 0, pd);
    check("timeout", 1, to);
    instr <= 16'h0802;
    valid <= 1'b1;
    repeat (6) begin
      @(posedge clk);
      check("taken asleep", 0, taken);
    end
    valid <= 1'b0;
    wake <= 1'b1;
    wait_sig(sleep, 1'b0);
    wake <= 1'b0;
    exec(16'h0802);
    exec(16'h088C);
    finish_test();
  end
endmodule : rsr_exec_bench
